// [rtl/pms_core.v]
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/10ps
`include "pms_regs.vh"
module pms_core #(
  parameter SLEEP_CYC = `PMS_SLEEP_CYC
) (
  // clock and reset
  input  wire        clk_in,
  input  wire        rstn_in,
  // register port
  input  wire [7:0]  addr_in,
  input  wire [31:0] wdata_in,
  input  wire        wr_in,
  input  wire        rd_in,
  output reg  [31:0] rdata_out,
  // control pin and samples
  input  wire        int_pin_in,
  input  wire [13:0] vbus_smp_in,
  input  wire [13:0] vsense_smp_in,
  // analog side
  output wire [9:0]  dac_code_out,
  output wire [1:0]  dac_fsr_out,
  output wire [1:0]  state_out,
  output wire        bias_en_out
);

localparam ST_SLEEP = 2'b00;
localparam ST_WAKE  = 2'b01;
localparam ST_INT   = 2'b10;
localparam ST_READ  = 2'b11;
localparam integer READ_I   = `PMS_READ_CYC;
localparam integer WAKE_I   = `PMS_WAKE_CYC;
localparam integer SLP_I    = SLEEP_CYC;
localparam [15:0]  READ_CYC = READ_I[15:0];
localparam [15:0]  WAKE_CYC = WAKE_I[15:0];
localparam [15:0]  SLP_CYC  = SLP_I[15:0];

////////////////////////////////////////////////////////////
// configuration registers

reg        ovr_r;
reg        inten_r;
reg        sleep_r;
reg  [1:0] osel_r;
reg  [1:0] fsr_r;
reg        res_r;
reg        filt_r;
reg  [2:0] igain_r;
reg  [2:0] vgain_r;
reg  [3:0] smpl_r;

always @(posedge clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    ovr_r   <= 1'b0;
    inten_r <= 1'b0;
    sleep_r <= 1'b0;
    osel_r  <= 2'b00;
    fsr_r   <= 2'b00;
    res_r   <= 1'b0;
    filt_r  <= 1'b0;
    igain_r <= 3'h0;
    vgain_r <= 3'h0;
    smpl_r  <= `PMS_SMPL_RST;
  end else if (wr_in) begin
    if (addr_in == `PMS_A_CTRL) begin
      ovr_r   <= wdata_in[`PMS_C_OVR];
      inten_r <= wdata_in[`PMS_C_INTEN];
      sleep_r <= wdata_in[`PMS_C_SLEEP];
      osel_r  <= wdata_in[`PMS_C_OSEL+1:`PMS_C_OSEL];
      fsr_r   <= wdata_in[`PMS_C_FSR+1:`PMS_C_FSR];
      res_r   <= wdata_in[`PMS_C_RES14];
      filt_r  <= wdata_in[`PMS_C_FILT];
    end else if (addr_in == `PMS_A_GAIN) begin
      igain_r <= wdata_in[`PMS_G_IGAIN+2:`PMS_G_IGAIN];
      vgain_r <= wdata_in[`PMS_G_VGAIN+2:`PMS_G_VGAIN];
    end else if (addr_in == `PMS_A_SMPL) begin
      smpl_r  <= wdata_in[3:0];
    end
  end
end

////////////////////////////////////////////////////////////
// power state sequencer

reg  [1:0]  state_r;
reg  [15:0] low_cnt_r;
reg  [15:0] wake_cnt_r;
reg         hold_r;

// override clear: pin alone
wire ctl = ovr_r ? inten_r : int_pin_in;
wire free_run = (osel_r != 2'b00);

// override goes at once, pin must stay low the read time
wire read_go = (state_r == ST_INT) && !ctl &&
               (ovr_r || low_cnt_r >= READ_CYC - 16'h0001);
wire slp_tmo = !ctl && (low_cnt_r >= SLP_CYC - 16'h0001);
wire sleep_go = sleep_r ||
                ((state_r == ST_READ) && slp_tmo);

always @(posedge clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    low_cnt_r <= 16'h0000;
  end else if (ctl) begin
    low_cnt_r <= 16'h0000;
  end else if (low_cnt_r != 16'hFFFF) begin
    low_cnt_r <= low_cnt_r + 16'h0001;
  end
end

always @(posedge clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    state_r    <= ST_SLEEP;
    wake_cnt_r <= 16'h0000;
  end else if (sleep_go) begin
    state_r    <= ST_SLEEP;
    wake_cnt_r <= 16'h0000;
  end else begin
    case (state_r)
      ST_SLEEP: begin
        wake_cnt_r <= 16'h0000;
        if (ctl)
          state_r <= ST_WAKE;
      end
      ST_WAKE: begin
        if (!ctl) begin
          state_r <= ST_SLEEP;
        end else if (wake_cnt_r >= WAKE_CYC - 16'h0001) begin
          state_r <= ST_INT;
        end else begin
          wake_cnt_r <= wake_cnt_r + 16'h0001;
        end
      end
      ST_INT: begin
        if (read_go)
          state_r <= ST_READ;
      end
      default: begin
        if (ctl)
          state_r <= ST_INT;
      end
    endcase
  end
end

////////////////////////////////////////////////////////////
// sampling and accumulation

reg  [7:0]  conv_cnt_r;
reg  [11:0] cnt_r;
reg  [38:0] psum_r;
reg  [24:0] isum_r;
reg  [24:0] vsum_r;

wire [7:0]  conv_base = res_r ? `PMS_CONV14_CYC : `PMS_CONV11_CYC;
// post filter stretches each conversion by half
wire [7:0]  conv_per = conv_base + (filt_r ? {1'b0, conv_base[7:1]} : 8'h00);
wire [11:0] n_tgt = (smpl_r > 4'hB) ? `PMS_MAX_SMPL : (12'h001 << smpl_r);
wire [11:0] end_cnt = free_run ? n_tgt : `PMS_MAX_SMPL;
wire        integ = (state_r == ST_INT) && !hold_r;
wire        tick = integ && (conv_cnt_r == conv_per - 8'h01);
wire [11:0] cnt_add = cnt_r + 12'h001;
wire        period_end = tick && (cnt_add == end_cnt);
wire [27:0] prod = vbus_smp_in * vsense_smp_in;
wire [38:0] p_add = psum_r + {11'h000, prod};
wire [24:0] i_add = isum_r + {11'h000, vsense_smp_in};
wire [24:0] v_add = vsum_r + {11'h000, vbus_smp_in};

always @(posedge clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    conv_cnt_r <= 8'h00;
    cnt_r      <= 12'h000;
    psum_r     <= 39'h0;
    isum_r     <= 25'h0;
    vsum_r     <= 25'h0;
    hold_r     <= 1'b0;
  end else if (state_r != ST_INT || read_go) begin
    // leaving or outside Integrate: partial period dropped
    conv_cnt_r <= 8'h00;
    cnt_r      <= 12'h000;
    psum_r     <= 39'h0;
    isum_r     <= 25'h0;
    vsum_r     <= 25'h0;
    hold_r     <= 1'b0;
  end else if (period_end) begin
    conv_cnt_r <= 8'h00;
    cnt_r      <= 12'h000;
    psum_r     <= 39'h0;
    isum_r     <= 25'h0;
    vsum_r     <= 25'h0;
    hold_r     <= !free_run;
  end else if (tick) begin
    conv_cnt_r <= 8'h00;
    cnt_r      <= cnt_add;
    psum_r     <= p_add;
    isum_r     <= i_add;
    vsum_r     <= v_add;
  end else if (integ) begin
    conv_cnt_r <= conv_cnt_r + 8'h01;
  end
end

////////////////////////////////////////////////////////////
// averaging divider

reg         div_busy_r;
reg  [5:0]  div_step_r;
reg  [39:0] div_dvd_r;
reg  [12:0] div_rem_r;
reg  [38:0] div_q_r;
reg  [11:0] div_den_r;
reg  [1:0]  div_sel_r;

// pin mode Read with samples, or any completed period
wire snap_rd = read_go && !free_run && !hold_r && (cnt_r != 12'h000);
wire snap = period_end || snap_rd;
wire [11:0] snap_den = period_end ? cnt_add : cnt_r;
wire is_pwr = (osel_r == 2'b00) || (osel_r == 2'b11);
reg  [38:0] snap_dvd;

always @* begin
  if (is_pwr)
    snap_dvd = period_end ? p_add : psum_r;
  else if (osel_r == 2'b01)
    snap_dvd = {14'h0000, (period_end ? i_add : isum_r)};
  else
    snap_dvd = {14'h0000, (period_end ? v_add : vsum_r)};
end

// two restoring steps a clock: a one-sample free-run period
// must not restart the divider before its result lands
localparam DIV_ST = 2;
wire [12:0]       stg_rem [0:DIV_ST];
wire [DIV_ST-1:0] stg_q;
genvar            g;

assign stg_rem[0] = div_rem_r;

generate
  for (g = 0; g < DIV_ST; g = g + 1) begin : g_div
    wire [12:0] try_w = {stg_rem[g][11:0], div_dvd_r[39-g]};
    wire        ge_w  = (try_w >= {1'b0, div_den_r});
    assign stg_q[DIV_ST-1-g] = ge_w;
    assign stg_rem[g+1]      = ge_w ? (try_w - {1'b0, div_den_r}) : try_w;
  end
endgenerate

wire        div_done = div_busy_r && (div_step_r == 6'd19);
wire [38:0] q_fin    = {div_q_r[36:0], stg_q};

always @(posedge clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    div_busy_r <= 1'b0;
    div_step_r <= 6'd0;
    div_dvd_r  <= 40'h0;
    div_rem_r  <= 13'h0000;
    div_q_r    <= 39'h0;
    div_den_r  <= 12'h000;
    div_sel_r  <= 2'b00;
  end else if (state_r == ST_SLEEP) begin
    div_busy_r <= 1'b0;
    div_step_r <= 6'd0;
  end else if (snap) begin
    div_busy_r <= 1'b1;
    div_step_r <= 6'd0;
    div_dvd_r  <= {1'b0, snap_dvd};
    div_rem_r  <= 13'h0000;
    div_q_r    <= 39'h0;
    div_den_r  <= snap_den;
    div_sel_r  <= is_pwr ? 2'b00 : osel_r;
  end else if (div_busy_r) begin
    div_rem_r  <= stg_rem[DIV_ST];
    div_dvd_r  <= {div_dvd_r[37:0], 2'b00};
    div_q_r    <= q_fin;
    div_step_r <= div_step_r + 6'd1;
    if (div_done)
      div_busy_r <= 1'b0;
  end
end

////////////////////////////////////////////////////////////
// gain and output code

reg  [3:0]  gsh;
reg  [9:0]  code;
wire [47:0] q_sh = {9'h000, q_fin} << gsh;

always @* begin
  if (div_sel_r == 2'b00)
    gsh = {1'b0, igain_r} + {1'b0, vgain_r};
  else if (div_sel_r == 2'b01)
    gsh = {1'b0, igain_r};
  else
    gsh = {1'b0, vgain_r};
  if (div_sel_r == 2'b00)
    code = (|q_sh[47:28]) ? 10'h3FF : q_sh[27:18];
  else
    code = (|q_sh[47:14]) ? 10'h3FF : q_sh[13:4];
end

reg  [15:0] pres_r;
reg  [15:0] ires_r;
reg  [15:0] vres_r;
reg  [9:0]  dac_r;

always @(posedge clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    pres_r <= 16'h0000;
    ires_r <= 16'h0000;
    vres_r <= 16'h0000;
    dac_r  <= 10'h000;
  end else if (state_r == ST_SLEEP) begin
    pres_r <= 16'h0000;
    ires_r <= 16'h0000;
    vres_r <= 16'h0000;
    dac_r  <= 10'h000;
  end else if (div_done) begin
    // output holds until the next result lands
    dac_r <= code;
    if (div_sel_r == 2'b00)
      pres_r <= {code, 6'h00};
    else if (div_sel_r == 2'b01)
      ires_r <= {code, 6'h00};
    else
      vres_r <= {code, 6'h00};
  end
end

assign dac_code_out = dac_r;
assign dac_fsr_out  = fsr_r;
assign state_out    = state_r;
assign bias_en_out  = (state_r != ST_SLEEP);

////////////////////////////////////////////////////////////
// register read port

always @(posedge clk_in or negedge rstn_in) begin
  if (!rstn_in) begin
    rdata_out <= 32'h0000_0000;
  end else if (!rd_in) begin
    rdata_out <= 32'h0000_0000;
  end else if (addr_in == `PMS_A_CTRL) begin
    rdata_out <= {22'h000000, filt_r, res_r, fsr_r, osel_r,
                  1'b0, sleep_r, inten_r, ovr_r};
  end else if (addr_in == `PMS_A_GAIN) begin
    rdata_out <= {25'h0000000, vgain_r, 1'b0, igain_r};
  end else if (addr_in == `PMS_A_SMPL) begin
    rdata_out <= {28'h0000000, smpl_r};
  end else if (addr_in == `PMS_A_STAT) begin
    rdata_out <= {12'h000, state_r, hold_r, div_busy_r, 4'h0, cnt_r};
  end else if (addr_in == `PMS_A_PRES) begin
    rdata_out <= {16'h0000, pres_r};
  end else if (addr_in == `PMS_A_IRES) begin
    rdata_out <= {16'h0000, ires_r};
  end else if (addr_in == `PMS_A_VRES) begin
    rdata_out <= {16'h0000, vres_r};
  end else begin
    rdata_out <= 32'h0000_0000;
  end
end

endmodule

// [rtl/pms_regs.vh]
`ifndef PMS_REGS_VH
`define PMS_REGS_VH
// How it works
// - output code is the upper 10 bits of the latest result
// - output full-scale select picks 3.0, 2.0, 1.5 or 1.0 V swing
// - control pin high keeps the block in Integrate
// - override set and enable written 1 enters Integrate, pin ignored
// - Read entered only after pin held low for the read entry time
// - override set and enable written 0 enters Read
// - Read stops integration, starts sleep timer, latches output, low power; the sleep timer here counts from effective control low, not from Read entry
// - output code held until the next result (period end or Read entry) or sleep expiry
// - effective control low beyond sleep entry time enters Sleep
// - sleep bit forces Sleep
// - Sleep clears measurement registers and drops bias enable
// - Sleep left on Integrate request, after wake delay integration restarts
// - one of power, sense or bus calculation, to output and result registers
// - power mode sums bus times sense products over the period
// - period end divides summed value by sample count into result
// - averaged power drives the output when power is selected
// - current and voltage digital gains scale power before the 10-bit output
// - sample period set by resolution, post filter and sample count
// - sense voltage selection uses free-running integration
// - sense mode averages sense sum, applies current gain, upper 10 bits out
// - select field: 00 power pin, 01 sense free, 10 bus free, 11 power free
// - in pin mode, at 2048 samples integration stops and results are updated
// - free-run restarts each period; a period cut by Read is discarded
`define PMS_A_CTRL     8'h00
`define PMS_A_GAIN     8'h04
`define PMS_A_SMPL     8'h08
`define PMS_A_STAT     8'h0C
`define PMS_A_PRES     8'h10
`define PMS_A_IRES     8'h14
`define PMS_A_VRES     8'h18
`define PMS_C_OVR      0
`define PMS_C_INTEN    1
`define PMS_C_SLEEP    2
`define PMS_C_OSEL     4
`define PMS_C_FSR      6
`define PMS_C_RES14    8
`define PMS_C_FILT     9
`define PMS_G_IGAIN    0
`define PMS_G_VGAIN    4
`define PMS_CTRL_RST   32'h0000_0000
`define PMS_GAIN_RST   32'h0000_0000
`define PMS_SMPL_RST   4'h0
`define PMS_MAX_SMPL   12'h800
`define PMS_CLK_MHZ    10
`define PMS_T_READ_US  10
`define PMS_T_SLEEP_US 1000
`define PMS_T_WAKE_US  100
`define PMS_READ_CYC   (`PMS_T_READ_US * `PMS_CLK_MHZ)
`define PMS_SLEEP_CYC  (`PMS_T_SLEEP_US * `PMS_CLK_MHZ)
`define PMS_WAKE_CYC   (`PMS_T_WAKE_US * `PMS_CLK_MHZ)
`define PMS_CONV11_CYC 8'h20
`define PMS_CONV14_CYC 8'h80
`endif

// [verification/pms_core_asserts.sv]
`timescale 1ns/10ps
module pms_core_asserts #(
  parameter SLEEP_CYC = 300
) (
  // clock and reset
  input wire        clk_in,
  input wire        rstn_in,
  // register port
  input wire [7:0]  addr_in,
  input wire [31:0] wdata_in,
  input wire        wr_in,
  input wire        rd_in,
  input wire [31:0] rdata_out,
  // pin and output side
  input wire        int_pin_in,
  input wire [9:0]  dac_code_out,
  input wire [1:0]  dac_fsr_out,
  input wire [1:0]  state_out,
  input wire        bias_en_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  sequence wake_entry_s;
    state_out == 2'h0 ##1 state_out == 2'h1;
  endsequence
  sequence pin_fall_s;
    state_out == 2'h2 && $fell(int_pin_in);
  endsequence
  bias_decode_a: assert property (bias_en_out == (state_out != 2'h0))
    else $error("bias enable wrong");
  sleep_clear_a: assert property (state_out == 2'h0 && $past(state_out) == 2'h0 |-> dac_code_out == 10'h000)
    else $error("output not cleared in sleep");
  wake_hold_a: assert property (wake_entry_s |=> (state_out != 2'h2)[*8])
    else $error("integrate too soon after wake");
  int_entry_a: assert property ($changed(state_out) && state_out == 2'h2 |-> $past(state_out) != 2'h0)
    else $error("sleep went straight to integrate");
  read_entry_a: assert property ($changed(state_out) && state_out == 2'h3 |-> $past(state_out) == 2'h2)
    else $error("read entered from wrong state");
  pin_delay_a: assert property (pin_fall_s |=> (state_out == 2'h2)[*8])
    else $error("read entered too early");
  wake_stable_a: assert property (state_out == 2'h1 && $past(state_out) == 2'h1 |-> $stable(dac_code_out))
    else $error("output moved while waking");
  fsr_write_a: assert property (wr_in && addr_in == 8'h00 |=> dac_fsr_out == $past(wdata_in[7:6]))
    else $error("full scale select not taken");
  rdata_idle_a: assert property (!$past(rd_in) |-> rdata_out == 32'h0000_0000)
    else $error("read data outside read cycle");
endmodule
bind pms_core pms_core_asserts #(.SLEEP_CYC(SLEEP_CYC)) u_chk (.clk_in(clk_in), .rstn_in(rstn_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
  .int_pin_in(int_pin_in), .dac_code_out(dac_code_out), .dac_fsr_out(dac_fsr_out),
  .state_out(state_out), .bias_en_out(bias_en_out));

// [verification/pms_host_model.sv]
`timescale 1ns/10ps
module pms_host_model (
  // clock
  input  wire        clk_in,
  // bench requests
  input  wire        pin_req_in,
  input  wire [13:0] vbus_set_in,
  input  wire [13:0] vsense_set_in,
  // device side
  output reg         int_pin_out,
  output reg  [13:0] vbus_smp_out,
  output reg  [13:0] vsense_smp_out
);
  reg [7:0] low_cnt_r;
  initial begin
    int_pin_out = 1'b0;
    low_cnt_r = 8'hFF;
  end
  always @(posedge clk_in) begin
    vbus_smp_out <= vbus_set_in;
    vsense_smp_out <= vsense_set_in;
    if (int_pin_out)
      low_cnt_r <= 8'h00;
    else if (low_cnt_r != 8'hFF)
      low_cnt_r <= low_cnt_r + 8'h01;
    // short low pulses stretched to the read entry time
    int_pin_out <= pin_req_in && (int_pin_out || low_cnt_r >= 8'h64);
  end
endmodule

// [verification/tb_power_monitor_state_accum.sv]
`timescale 1ns/10ps
module tb_power_monitor_state_accum;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic [7:0]  gain;
    logic [13:0] vb;
    logic [13:0] vs;
    logic [7:0]  ra;
    logic [9:0]  code;
  } pms_row_t;
  logic        clk_in, rstn_in, wr_in, rd_in, pin_req;
  logic [7:0]  addr_in;
  logic [31:0] wdata_in;
  logic [13:0] vbus_set, vsense_set;
  wire  [31:0] rdata_out;
  wire         int_pin, bias_en_out;
  wire  [13:0] vbus_smp, vsense_smp;
  wire  [9:0]  dac_code_out;
  wire  [1:0]  dac_fsr_out, state_out;
  pms_row_t    rows [0:4];
  int          num_errors, total_checks, i;
  ////////////////////////////////////////////////////////////
  pms_core #(.SLEEP_CYC(300)) pms_core_inst (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .int_pin_in(int_pin),
    .vbus_smp_in(vbus_smp), .vsense_smp_in(vsense_smp), .dac_code_out(dac_code_out),
    .dac_fsr_out(dac_fsr_out), .state_out(state_out), .bias_en_out(bias_en_out));
  pms_host_model pms_host_model_inst (.clk_in(clk_in), .pin_req_in(pin_req), .vbus_set_in(vbus_set),
    .vsense_set_in(vsense_set), .int_pin_out(int_pin), .vbus_smp_out(vbus_smp), .vsense_smp_out(vsense_smp));
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    #3_000_000;
    num_errors++;
    final_report();
  end
  initial begin
    {rstn_in, wr_in, rd_in, pin_req, addr_in, wdata_in} = '0;
    vbus_set = 14'h0000;
    vsense_set = 14'h0000;
    rows[0] = '{8'h10, 8'h00, 14'h0000, 14'h1230, 8'h14, 10'h123};
    rows[1] = '{8'h50, 8'h02, 14'h0000, 14'h1230, 8'h14, 10'h3FF};
    rows[2] = '{8'hA0, 8'h10, 14'h1230, 14'h0000, 8'h18, 10'h246};
    rows[3] = '{8'hF0, 8'h00, 14'h2000, 14'h2000, 8'h10, 10'h100};
    rows[4] = '{8'h10, 8'h01, 14'h0000, 14'h0FF0, 8'h14, 10'h1FE};
    repeat (5) @(posedge clk_in);
    rstn_in <= 1'b1;
    cyc(1);
    check(32'(state_out), 32'h0);
    check(32'(bias_en_out), 32'h0);
    rd(8'h00);
    check(rdata_out, 32'h0);
    rd(8'h20);
    check(rdata_out, 32'h0);
    // free-running modes, one sample a period
    for (i = 0; i < 5; i++) begin
      wr(8'h04, {24'h0, rows[i].gain});
      wr(8'h00, {24'h0, rows[i].ctrl});
      vbus_set <= rows[i].vb;
      vsense_set <= rows[i].vs;
      pin_req <= 1'b1;
      cyc(1300);
      check(32'(dac_code_out), 32'(rows[i].code));
      check(32'(dac_fsr_out), 32'(rows[i].ctrl[7:6]));
      rd(rows[i].ra);
      check(rdata_out, {16'h0000, rows[i].code, 6'h00});
      @(posedge clk_in) pin_req <= 1'b0;
      cyc(400);
      check(32'(state_out), 32'h0);
      check(32'(dac_code_out), 32'h0);
    end
    // pin-controlled power period
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h0);
    vbus_set <= 14'h2000;
    vsense_set <= 14'h2000;
    pin_req <= 1'b1;
    cyc(1010);
    check(32'(state_out), 32'h2);
    @(posedge clk_in) pin_req <= 1'b0;
    cyc(60);
    check(32'(state_out), 32'h2);
    check(32'(dac_code_out), 32'h0);
    cyc(100);
    check(32'(state_out), 32'h3);
    check(32'(dac_code_out), 32'h100);
    rd(8'h10);
    check(rdata_out, 32'h4000);
    cyc(40);
    check(32'(dac_code_out), 32'h100);
    cyc(120);
    check(32'(state_out), 32'h0);
    // 14-bit filtered sense, two samples a period
    wr(8'h08, 32'h1);
    wr(8'h00, 32'h310);
    @(posedge clk_in) pin_req <= 1'b1;
    cyc(1192);
    rd(8'h0C);
    check(rdata_out, 32'h0008_0000);
    rd(8'h0C);
    check(rdata_out, 32'h0008_0001);
    cyc(190);
    rd(8'h0C);
    check(rdata_out, 32'h0009_0000);
    cyc(40);
    check(32'(dac_code_out), 32'h200);
    @(posedge clk_in) pin_req <= 1'b0;
    cyc(400);
    check(32'(state_out), 32'h0);
    // register overrides of the pin
    wr(8'h00, 32'h2);
    cyc(20);
    check(32'(state_out), 32'h0);
    wr(8'h00, 32'h3);
    cyc(990);
    check(32'(state_out), 32'h1);
    cyc(20);
    check(32'(state_out), 32'h2);
    @(posedge clk_in) pin_req <= 1'b1;
    wr(8'h00, 32'h1);
    cyc(3);
    check(32'(state_out), 32'h3);
    wr(8'h00, 32'h5);
    cyc(3);
    check(32'(state_out), 32'h0);
    check(32'(bias_en_out), 32'h0);
    final_report();
  end
endmodule
